// *** rtl/pws_pkg.sv ***
/*
 * pws_pkg: constants and types shared by the power-up / resume_from_sleep sequencer.
 * Assumes a 125 MHz clock and a synchronous active-high reset.
 */
// Behaviour
// - raise external-on once supply passes threshold
// - start oscillator, continue only once settled
// - raise regulator and core supplies, then release reset
// - reset rising edge enters the startup state
// - resume_from_sleep: download retained config, idle within 40us
// - retention array kept while retention supply powered
// - cold start: idle about 5us after startup
// - serial fast rate accepted only from idle
// - latch mode straps on reset rising edge
package pws_pkg;

	// clock rate and the timing figures, each in its own unit
	localparam int CLK_MHZ        = 125;
	localparam int WAKE_MAX_US    = 40;
	localparam int PLL_LOCK_US    = 5;
	localparam int OSC_SETTLE_US  = 1;
	localparam int SUPPLY_RISE_US = 1;

	// cycle counts derived from the figures
	localparam int WAKE_MAX_CYC    = WAKE_MAX_US * CLK_MHZ;
	localparam int PLL_LOCK_CYC    = PLL_LOCK_US * CLK_MHZ;
	localparam int OSC_SETTLE_CYC  = OSC_SETTLE_US * CLK_MHZ;
	localparam int SUPPLY_RISE_CYC = SUPPLY_RISE_US * CLK_MHZ;

	// retention array shape and timer width
	localparam int RET_WORDS = 16;
	localparam int RET_AW    = 4;
	localparam int RET_DW    = 8;
	localparam int TMR_W     = 13;

	// strap layout
	localparam int STRAP_POL_BIT = 0;
	localparam int STRAP_PHA_BIT = 1;

	// sequencer states
	typedef enum logic [2:0] {
		PWS_OFF      = 3'b000,
		PWS_OSC      = 3'b001,
		PWS_SUPPLY   = 3'b010,
		PWS_STARTUP  = 3'b011,
		PWS_DOWNLOAD = 3'b100,
		PWS_IDLE     = 3'b101
	} pws_state_t;

endpackage

// *** rtl/pws_ret_if.sv ***
/*
 * pws_ret_if: retention array read port between sequencer and array.
 * Assumes both ends sit on the same clock.
 */
`timescale 1ns/100ps
interface pws_ret_if;
	import pws_pkg::*;
	logic [RET_AW-1:0] rd_addr;	// word being downloaded
	logic [RET_DW-1:0] rd_data;	// word content, one cycle later
	modport seq (output rd_addr, input rd_data);
	modport mem (input rd_addr, output rd_data);
endinterface

// *** rtl/pws_ret_array.sv ***
/*
 * pws_ret_array: configuration array powered from the retention supply.
 * Assumes the surrounding domain runs while retention supply is on.
 */
`timescale 1ns/100ps
module pws_ret_array
	import pws_pkg::*;
(
	// clock
	input  wire logic            clk_in,
	// retention supply and write port
	input  wire logic            ret_supply_in,
	input  wire logic            wr_en_in,
	input  wire logic [RET_AW-1:0] wr_addr_in,
	input  wire logic [RET_DW-1:0] wr_data_in,
	// read side
	pws_ret_if.mem               rd
);
	// storage deliberately has no reset: contents survive core reset
	logic [RET_DW-1:0] mem [RET_WORDS];

	// contents kept only while retention supply holds; lost otherwise
	always_ff @(posedge clk_in) begin
		for (int i = 0; i < RET_WORDS; i++) begin
			if (!ret_supply_in) begin
				mem[i] <= '0;
			end else if (wr_en_in && wr_addr_in == RET_AW'(i)) begin
				mem[i] <= wr_data_in;
			end
		end
		rd.rd_data <= mem[rd.rd_addr];
	end
endmodule // pws_ret_array

// *** rtl/pws_sequencer.sv ***
/*
 * pws_sequencer: power-up / resume_from_sleep sequencer top.
 * Assumes supply comparator, retention supply, resume_from_sleep and strap inputs are
 * synchronous to clk_in.
 */
`timescale 1ns/100ps
module pws_sequencer
	import pws_pkg::*;
(
	// clock and reset
	input  wire logic              clk_in,
	input  wire logic              rst_in,
	// supplies and resume_from_sleep request
	input  wire logic              supply_above_on_in,
	input  wire logic              retention_supply_pin_in,
	input  wire logic              resume_from_sleep_in,
	// mode straps
	input  wire logic [1:0]        strap_in,
	// retention array writes from the configuration path
	input  wire logic              cfg_wr_en_in,
	input  wire logic [RET_AW-1:0] cfg_wr_addr_in,
	input  wire logic [RET_DW-1:0] cfg_wr_data_in,
	// sequencer outputs
	output logic                   external_on_output_out,
	output logic                   crystal_oscillator_en_out,
	output logic                   regulator_supply_out_out,
	output logic                   digital_core_supply_out,
	output logic                   reset_release_line_n_out,
	output logic                   idle_out,
	output logic                   fast_serial_ok_out,
	output logic                   wake_case_out,
	output logic                   spi_pol_out,
	output logic                   spi_pha_out,
	output logic                   cfg_valid_out,
	output logic [RET_AW-1:0]      cfg_addr_out,
	output logic [RET_DW-1:0]      cfg_data_out
);
	pws_state_t        state;	// current step
	pws_state_t        next_state;	// next step
	logic [TMR_W-1:0]  tmr;	// cycles in current step
	logic [RET_AW-1:0] dl_addr;	// download pointer
	logic              dl_pend;	// read data due this cycle
	logic              wake;	// this start follows deep sleep
	logic              rst_line_q;	// reset line one cycle ago
	pws_ret_if         ret();

	// named decodes
	wire in_off   = (state == PWS_OFF);
	wire in_start = (state == PWS_STARTUP);
	wire in_dl    = (state == PWS_DOWNLOAD);
	wire osc_done = (state == PWS_OSC) && (tmr == TMR_W'(OSC_SETTLE_CYC - 1));
	wire sup_done = (state == PWS_SUPPLY) && (tmr == TMR_W'(SUPPLY_RISE_CYC - 1));
	wire pll_done = in_start && (tmr == TMR_W'(PLL_LOCK_CYC - 1));
	wire dl_last  = in_dl && (dl_addr == RET_AW'(RET_WORDS - 1));
	wire rst_rise = reset_release_line_n_out && !rst_line_q;
	assign ret.rd_addr = dl_addr;

	pws_ret_array u_ret (
		.clk_in     (clk_in),
		.ret_supply_in(retention_supply_pin_in),
		.wr_en_in   (cfg_wr_en_in),
		.wr_addr_in (cfg_wr_addr_in),
		.wr_data_in (cfg_wr_data_in),
		.rd         (ret.mem)
	);

	// step selection; resume_from_sleep start goes through download, cold start through pll wait
	always_comb begin
		next_state = state;
		case (state)
			PWS_OFF:      if (supply_above_on_in) next_state = PWS_OSC;
			PWS_OSC:      if (osc_done) next_state = PWS_SUPPLY;
			PWS_SUPPLY:   if (sup_done) next_state = PWS_STARTUP;
			PWS_STARTUP: begin
				if (wake) next_state = PWS_DOWNLOAD;
				else if (pll_done) next_state = PWS_IDLE;
			end
			PWS_DOWNLOAD: if (dl_last) next_state = PWS_IDLE;
			PWS_IDLE:     next_state = PWS_IDLE;
			default:      next_state = PWS_OFF;
		endcase
		// supply loss drops everything back to off
		if (!supply_above_on_in) next_state = PWS_OFF;
	end

	// state, timer and download pointer
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			state   <= PWS_OFF;
			tmr     <= '0;
			dl_addr <= '0;
			dl_pend <= 1'b0;
		end else begin
			state   <= next_state;
			tmr     <= (next_state != state) ? '0 : tmr + 1'b1;
			dl_addr <= in_dl ? dl_addr + 1'b1 : '0;
			dl_pend <= in_dl;
		end
	end

	// case capture at supply rise: recorded once per start
	always_ff @(posedge clk_in) begin
		if (rst_in) wake <= 1'b0;
		else if (in_off) wake <= resume_from_sleep_in && retention_supply_pin_in;
	end

	// supply outputs; each follows its step so order is fixed
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			external_on_output_out    <= 1'b0;
			crystal_oscillator_en_out <= 1'b0;
			regulator_supply_out_out  <= 1'b0;
			digital_core_supply_out   <= 1'b0;
			reset_release_line_n_out  <= 1'b0;
			rst_line_q                <= 1'b0;
		end else begin
			external_on_output_out    <= !(next_state == PWS_OFF);
			crystal_oscillator_en_out <= !(next_state == PWS_OFF);
			regulator_supply_out_out  <= next_state >= PWS_SUPPLY;
			digital_core_supply_out   <= next_state >= PWS_SUPPLY;
			reset_release_line_n_out  <= next_state >= PWS_STARTUP;
			rst_line_q                <= reset_release_line_n_out;
		end
	end

	// straps sampled at the reset line rising edge
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			spi_pol_out <= 1'b0;
			spi_pha_out <= 1'b0;
		end else if (rst_rise) begin
			spi_pol_out <= strap_in[STRAP_POL_BIT];
			spi_pha_out <= strap_in[STRAP_PHA_BIT];
		end
	end

	// download stream and status
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			cfg_valid_out      <= 1'b0;
			cfg_addr_out       <= '0;
			cfg_data_out       <= '0;
			idle_out           <= 1'b0;
			fast_serial_ok_out <= 1'b0;
			wake_case_out      <= 1'b0;
		end else begin
			cfg_valid_out      <= dl_pend;
			cfg_addr_out       <= dl_addr - 1'b1;
			cfg_data_out       <= ret.rd_data;
			// idle is announced only once the last downloaded word is out,
			// so the host never sees idle with configuration still in flight
			idle_out           <= (next_state == PWS_IDLE) && !in_dl;
			fast_serial_ok_out <= (next_state == PWS_IDLE) && !in_dl;
			wake_case_out      <= wake;
		end
	end

	// startup-dwell counter for the resume_from_sleep bound check
	logic [TMR_W-1:0] dwell;
	always_ff @(posedge clk_in) begin
		if (rst_in || !reset_release_line_n_out) dwell <= '0;
		else if (!idle_out) dwell <= dwell + 1'b1;
	end

	property p_on_order;
		@(posedge clk_in) disable iff (rst_in)
		$rose(regulator_supply_out_out) |-> external_on_output_out && crystal_oscillator_en_out;
	endproperty
	a_on_order: assert property (p_on_order) else $error("supply before on");
	property p_osc_settle;
		@(posedge clk_in) disable iff (rst_in)
		$rose(crystal_oscillator_en_out) |-> !regulator_supply_out_out [*8];
	endproperty
	a_osc_settle: assert property (p_osc_settle) else $error("osc not settled");
	property p_rst_after;
		@(posedge clk_in) disable iff (rst_in)
		reset_release_line_n_out |-> regulator_supply_out_out && digital_core_supply_out;
	endproperty
	a_rst_after: assert property (p_rst_after) else $error("reset early");
	property p_rise_start;
		@(posedge clk_in) disable iff (rst_in)
		$rose(reset_release_line_n_out) |-> in_start;
	endproperty
	a_rise_start: assert property (p_rise_start) else $error("not startup");
	property p_wake_bound;
		@(posedge clk_in) disable iff (rst_in)
		reset_release_line_n_out |-> dwell <= TMR_W'(WAKE_MAX_CYC);
	endproperty
	a_wake_bound: assert property (p_wake_bound) else $error("idle too late");
	// cold start timing is checked on the dwell counter, not a long delay,
	// since a 625-cycle delay would make the property slow to evaluate
	property p_cold;
		@(posedge clk_in) disable iff (rst_in)
		$fell(in_start) && !wake && supply_above_on_in |-> dwell == TMR_W'(PLL_LOCK_CYC);
	endproperty
	a_cold: assert property (p_cold) else $error("cold timing");
	property p_cold_bound;
		@(posedge clk_in) disable iff (rst_in)
		in_start && !wake |-> dwell < TMR_W'(PLL_LOCK_CYC);
	endproperty
	a_cold_bound: assert property (p_cold_bound) else $error("pll wait too long");
	// the last retained word must be out by the time idle is shown
	property p_dl_done;
		@(posedge clk_in) disable iff (rst_in)
		$rose(idle_out) && wake |-> cfg_valid_out && cfg_addr_out == RET_AW'(RET_WORDS - 1);
	endproperty
	a_dl_done: assert property (p_dl_done) else $error("idle before download end");
	property p_fast;
		@(posedge clk_in) disable iff (rst_in)
		fast_serial_ok_out |-> idle_out && reset_release_line_n_out;
	endproperty
	a_fast: assert property (p_fast) else $error("fast before idle");
	property p_strap;
		@(posedge clk_in) disable iff (rst_in)
		rst_rise |=> spi_pol_out == $past(strap_in[0]) && spi_pha_out == $past(strap_in[1]);
	endproperty
	a_strap: assert property (p_strap) else $error("strap not latched");
	property p_dl_wake;
		@(posedge clk_in) disable iff (rst_in)
		cfg_valid_out |-> wake;
	endproperty
	a_dl_wake: assert property (p_dl_wake) else $error("download on cold");
	c_cold: cover property (@(posedge clk_in) $rose(idle_out) && !wake);
	c_wake: cover property (@(posedge clk_in) $rose(idle_out) && wake);
	c_drop: cover property (@(posedge clk_in) idle_out && !supply_above_on_in);
endmodule // pws_sequencer

// *** tb/pws_host_model.sv ***
/*
 * pws_host_model: host controller on the serial side of the sequencer.
 * Assumes it shares clk_in with the device and sets its mode when told.
 */
`timescale 1ns/100ps
module pws_host_model (
	// clock
	input  wire logic       clk_in,
	// device status
	input  wire logic       fast_serial_ok_in,
	input  wire logic       reset_release_line_n_in,
	// wanted serial mode from the bench
	input  wire logic [1:0] mode_in,
	// strap pins and rate choice
	output logic      [1:0] strap_out,
	output logic            fast_rate_out
);
	// straps change only just after an edge, so they are stable at the latch
	always_ff @(posedge clk_in) begin
		strap_out <= mode_in;
	end
	// fast rate only from idle; slow-rate accesses stay slow always
	assign fast_rate_out = fast_serial_ok_in & reset_release_line_n_in;
endmodule // pws_host_model

// *** tb/tb_powerup_resume_from_sleep_sequencer.sv ***
/*
 * tb_powerup_resume_from_sleep_sequencer: self-checking bench for the sequencer.
 * Assumes the cycle figures of pws_pkg and the host model beside it.
 */
`timescale 1ns/100ps
module tb_powerup_resume_from_sleep_sequencer;
	import pws_pkg::*;
	// stimulus
	logic clk_in = 0, rst_in = 1, supply_above_on_in = 0, retention_supply_pin_in = 1;
	logic resume_from_sleep_in = 0, cfg_wr_en_in = 0;
	logic [RET_AW-1:0] cfg_wr_addr_in = '0;
	logic [RET_DW-1:0] cfg_wr_data_in = '0;
	logic [1:0]        strap_in, mode = 2'h0;
	// observed outputs
	logic external_on_output_out, crystal_oscillator_en_out, regulator_supply_out_out;
	logic digital_core_supply_out, reset_release_line_n_out, idle_out, fast_serial_ok_out;
	logic wake_case_out, spi_pol_out, spi_pha_out, cfg_valid_out, fast_rate;
	logic [RET_AW-1:0] cfg_addr_out;
	logic [RET_DW-1:0] cfg_data_out;
	logic [7:0]        outs;
	int                n_mismatch = 0, check_count = 0, r;
	// row: wake, strap[1:0], then expected wake case, polarity, phase
	logic [5:0] rows [4] = '{6'h00, 6'h35, 6'h0a, 6'h3f};
	assign outs = {external_on_output_out, crystal_oscillator_en_out, regulator_supply_out_out,
		digital_core_supply_out, reset_release_line_n_out, idle_out, fast_serial_ok_out,
		cfg_valid_out};
	always #4 clk_in = ~clk_in;
	pws_sequencer u_dut (.clk_in, .rst_in, .supply_above_on_in, .retention_supply_pin_in,
		.resume_from_sleep_in, .strap_in, .cfg_wr_en_in, .cfg_wr_addr_in, .cfg_wr_data_in,
		.external_on_output_out, .crystal_oscillator_en_out, .regulator_supply_out_out,
		.digital_core_supply_out, .reset_release_line_n_out, .idle_out, .fast_serial_ok_out,
		.wake_case_out, .spi_pol_out, .spi_pha_out, .cfg_valid_out, .cfg_addr_out,
		.cfg_data_out);
	pws_host_model u_host (.clk_in, .fast_serial_ok_in(fast_serial_ok_out),
		.reset_release_line_n_in(reset_release_line_n_out), .mode_in(mode),
		.strap_out(strap_in), .fast_rate_out(fast_rate));
	// one comparison, counted; mismatches print at once
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic print_verdict();
		if (n_mismatch == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// fill the retention array with an address-derived pattern
	task automatic load_array();
		for (int i = 0; i < RET_WORDS; i++) begin
			@(posedge clk_in);
			cfg_wr_en_in <= 1'b1;
			cfg_wr_addr_in <= 4'(i);
			cfg_wr_data_in <= {~4'(i), 4'(i)};
		end
		@(posedge clk_in);
		cfg_wr_en_in <= 1'b0;
	endtask
	// one start from off to idle; clr means the array was wiped meanwhile
	task automatic run_seq(input logic wk, input logic clr);
		int n, t_on, t_reg, t_rst, t_cfg, np;
		@(posedge clk_in);
		supply_above_on_in <= 1'b0;
		resume_from_sleep_in <= wk;
		repeat (3) @(posedge clk_in);
		supply_above_on_in <= 1'b1;
		{n, np, t_on, t_reg, t_rst, t_cfg} = {32'd0, 32'd0, -32'sd1, -32'sd1, -32'sd1, -32'sd1};
		while (idle_out !== 1'b1 && n < 6000) begin
			@(posedge clk_in);
			#1 n++;
			if (t_on < 0 && external_on_output_out === 1'b1) begin
				t_on = n;
				chk(crystal_oscillator_en_out, 1);
			end
			if (t_reg < 0 && regulator_supply_out_out === 1'b1) begin
				t_reg = n;
				chk({digital_core_supply_out, reset_release_line_n_out}, 2);
			end
			if (t_rst < 0 && reset_release_line_n_out === 1'b1) t_rst = n;
			if (cfg_valid_out === 1'b1) begin
				if (t_cfg < 0) t_cfg = n;
				chk(cfg_addr_out, np);
				chk(cfg_data_out, clr ? 8'h00 : {~4'(np), 4'(np)});
				np++;
			end
			if (idle_out !== 1'b1) chk({fast_serial_ok_out, fast_rate}, 0);
		end
		chk(t_on, 1);
		chk(t_reg, 1 + OSC_SETTLE_CYC);
		chk(t_rst, t_reg + SUPPLY_RISE_CYC);
		chk(np, wk ? RET_WORDS : 0);
		chk({fast_serial_ok_out, fast_rate}, 3);
		if (wk) begin
			chk(t_cfg, t_rst + 3);
			chk(n <= t_rst + WAKE_MAX_CYC && n >= t_cfg + 15, 1);
		end else
			chk(n, t_rst + PLL_LOCK_CYC);
	endtask
	// watchdog: a few thousand cycles are expected, allow many times that
	initial begin
		#400000;
		n_mismatch++;
		print_verdict();
	end
	initial begin
		repeat (6) @(posedge clk_in);
		rst_in <= 1'b0;
		#1 chk(outs, 0);
		// ordinary starts from the table
		for (r = 0; r < 4; r++) begin
			@(posedge clk_in);
			mode <= rows[r][4:3];
			load_array();
			run_seq(rows[r][5], 0);
			chk(wake_case_out, rows[r][2]);
			chk({spi_pha_out, spi_pol_out}, {rows[r][0], rows[r][1]});
			@(posedge clk_in);
			mode <= ~rows[r][4:3];
			repeat (4) @(posedge clk_in);
			#1 chk({spi_pha_out, spi_pol_out}, {rows[r][0], rows[r][1]});
		end
		// retention supply lost while idle wipes the array
		load_array();
		@(posedge clk_in);
		retention_supply_pin_in <= 1'b0;
		repeat (2) @(posedge clk_in);
		retention_supply_pin_in <= 1'b1;
		run_seq(1, 1);
		// supply drop in mid-sequence returns to off, then restarts cleanly
		@(posedge clk_in);
		supply_above_on_in <= 1'b0;
		repeat (3) @(posedge clk_in);
		supply_above_on_in <= 1'b1;
		repeat (200) @(posedge clk_in);
		supply_above_on_in <= 1'b0;
		repeat (3) @(posedge clk_in);
		#1 chk(outs, 0);
		run_seq(0, 0);
		// reset while idle clears every output
		@(posedge clk_in);
		rst_in <= 1'b1;
		@(posedge clk_in);
		rst_in <= 1'b0;
		#1 chk(outs, 0);
		chk({wake_case_out, spi_pol_out, spi_pha_out, cfg_data_out, cfg_addr_out}, 0);
		print_verdict();
	end
endmodule // tb_powerup_resume_from_sleep_sequencer
